// [pkg/bics_defs.vh]
// Register map, field layout and reset values of the bus interface config/status bank
`ifndef BICS_DEFS_VH
`define BICS_DEFS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define BICS_IDX_W           21
`define BICS_IDX_SYS_CFG     21'h1F0080
`define BICS_IDX_BUS_LOCK    21'h1F0083
`define BICS_IDX_SDRAM_CFG   21'h1F0084
`define BICS_IDX_SYS_STAT    21'h1F0086
`define BICS_IDX_SYS_STAT_CL 21'h1F0087
`define BICS_IDX_TEN_LIMIT   21'h1F008C
`define BICS_IDX_TEN_COUNT   21'h1F008D

// ****************************************************************
// Field widths and positions
// ****************************************************************
`define BICS_SYS_CFG_W       22
`define BICS_HALF_W          16
`define BICS_SDRAM_EN_BIT    0
`define BICS_ERR_SELF_BIT    19
`define BICS_ERR_SDRAM_BIT   18
`define BICS_ERR_ADMA_BIT    17
`define BICS_ERR_BCAST_BIT   16
`define BICS_STRAP_HI_W      8
`define BICS_STRAP_LO_W      4

// ****************************************************************
// Reset values and special counts
// ****************************************************************
`define BICS_SYS_CFG_RST     22'h009067
`define BICS_HALF_ZERO       16'h0000
`define BICS_TEN_DISABLED    16'hFFFF
`define BICS_TEN_EXPIRED     16'h0000

// ****************************************************************
// AXI4-Lite responses
// ****************************************************************
`define BICS_RESP_OKAY       2'h0
`define BICS_RESP_SLVERR     2'h2

`endif

// [rtl/bics_sync2.v]
// Two-flop synchroniser for pin levels entering the core clock domain
`timescale 1ns/10ps
`default_nettype none

module bics_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             aclk,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  // No reset: the level must keep flowing while reset is held so that
  // straps can be caught before release
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge aclk)
  begin
    meta_q <= async_in;
    sync_q <= meta_q;
  end

  assign sync_out = sync_q;

endmodule // bics_sync2

`default_nettype wire

// [rtl/bics_regs.v]
// Bus interface configuration and status register bank with AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "bics_defs.vh"

// Summary of operation
// RULE1: system config resets low bits to 0x009067
// RULE2: user mode, strap off: config write once
// RULE3: SDRAM config uses same write-once lock
// RULE4: strap on at reset: unlimited user writes
// RULE5: supervisor writes to configs always take effect
// RULE6: SDRAM config resets zero, SDRAM disabled
// RULE7: bus lock resets zero, upper half zero
// RULE8: status read-only, straps in low nibbles
// RULE9: plain status read leaves contents unchanged
// RULE10: alias read returns then clears bits 19:16
// RULE11: set self-read error on illegal self read
// RULE12: set SDRAM error on uninitialised SDRAM access
// RULE13: set auto-DMA error on uninitialised channel
// RULE14: set broadcast error on foreign broadcast read
// RULE15: tenure limit holds 16 bits, upper zero
// RULE16: tenure limit reads written value, not count
// RULE17: limit all ones disables the counter
// RULE18: tenure count read-only live, resets all ones
// RULE19: load on grant, decrement, request release
// RULE20: write-once state re-armed by reset only
module bics_regs #(
  parameter ADDR_W = 23
) (
  input  wire                        aclk,
  input  wire                        aresetn,
  // AXI4-Lite slave
  input  wire [ADDR_W-1:0]           s_axi_awaddr,
  input  wire                        s_axi_awvalid,
  output wire                        s_axi_awready,
  input  wire [31:0]                 s_axi_wdata,
  input  wire [3:0]                  s_axi_wstrb,
  input  wire                        s_axi_wvalid,
  output wire                        s_axi_wready,
  output wire [1:0]                  s_axi_bresp,
  output wire                        s_axi_bvalid,
  input  wire                        s_axi_bready,
  input  wire [ADDR_W-1:0]           s_axi_araddr,
  input  wire                        s_axi_arvalid,
  output wire                        s_axi_arready,
  output wire [31:0]                 s_axi_rdata,
  output wire [1:0]                  s_axi_rresp,
  output wire                        s_axi_rvalid,
  input  wire                        s_axi_rready,
  // Core state and strap pins
  input  wire                        supervisor_mode,
  input  wire                        config_write_unlock_strap,
  input  wire [`BICS_STRAP_HI_W-1:0] status_strap_hi,
  input  wire [`BICS_STRAP_LO_W-1:0] status_strap_lo,
  // Error events, one-cycle pulses from core logic
  input  wire                        self_read_evt,
  input  wire                        sdram_access_evt,
  input  wire                        auto_dma_uninit_evt,
  input  wire                        bcast_read_evt,
  // External bus mastership
  input  wire                        bus_master,
  output wire                        bus_release_req,
  // Configuration towards the bus interface
  output wire [`BICS_SYS_CFG_W-1:0]  system_config,
  output wire [`BICS_HALF_W-1:0]     bus_lock_control,
  output wire [`BICS_HALF_W-1:0]     sdram_config
);

  // ****************************************************************
  // Strap synchronisation and capture
  // ****************************************************************
  localparam STRAP_W = 1 + `BICS_STRAP_HI_W + `BICS_STRAP_LO_W;

  wire [STRAP_W-1:0] strap_s;
  reg                unlock_q;
  reg [`BICS_STRAP_HI_W-1:0] strap_hi_q;
  reg [`BICS_STRAP_LO_W-1:0] strap_lo_q;

  bics_sync2 #(
    .WIDTH    (STRAP_W)
  ) i_bics_sync2 (
    .aclk     (aclk),
    .async_in ({config_write_unlock_strap, status_strap_hi, status_strap_lo}),
    .sync_out (strap_s)
  );

  // Straps are sampled every cycle while reset is held; the last value
  // before release is kept
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unlock_q   <= strap_s[STRAP_W-1];
      strap_hi_q <= strap_s[STRAP_W-2:`BICS_STRAP_LO_W];
      strap_lo_q <= strap_s[`BICS_STRAP_LO_W-1:0];
    end
  end

  // ****************************************************************
  // Byte-lane merge
  // ****************************************************************
  function [31:0] bics_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      i;
    begin
      bics_merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          bics_merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  // ****************************************************************
  // Write channel
  // ****************************************************************
  reg                awready_q;
  reg                wready_q;
  reg                bvalid_q;
  reg [1:0]          bresp_q;
  reg                aw_got_q;
  reg                w_got_q;
  reg [`BICS_IDX_W-1:0] widx_q;
  reg [31:0]         wdata_q;
  reg [3:0]          wstrb_q;

  wire wr_do = aw_got_q & w_got_q & ~bvalid_q;
  wire wr_sys   = wr_do & (widx_q == `BICS_IDX_SYS_CFG);
  wire wr_lock  = wr_do & (widx_q == `BICS_IDX_BUS_LOCK);
  wire wr_sdram = wr_do & (widx_q == `BICS_IDX_SDRAM_CFG);
  wire wr_limit = wr_do & (widx_q == `BICS_IDX_TEN_LIMIT);
  wire wr_known = wr_sys | wr_lock | wr_sdram | wr_limit;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `BICS_RESP_OKAY;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      widx_q    <= {`BICS_IDX_W{1'b0}};
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awready_q <= 1'b0;
        aw_got_q  <= 1'b1;
        widx_q    <= s_axi_awaddr[`BICS_IDX_W+1:2];
      end
      if (s_axi_wvalid && wready_q)
      begin
        wready_q <= 1'b0;
        w_got_q  <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        // Read-only and unmapped words answer SLVERR; locked writes stay OKAY
        bresp_q  <= wr_known ? `BICS_RESP_OKAY : `BICS_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Configuration registers and write-once lock
  // ****************************************************************
  reg [`BICS_SYS_CFG_W-1:0] sys_cfg_q;
  reg [`BICS_HALF_W-1:0]    lock_q;
  reg [`BICS_HALF_W-1:0]    sdram_q;
  reg [`BICS_HALF_W-1:0]    limit_q;
  reg                       sys_written_q;
  reg                       sdram_written_q;

  wire [31:0] sys_new   = bics_merge({10'h000, sys_cfg_q}, wdata_q, wstrb_q);
  wire [31:0] lock_new  = bics_merge({16'h0000, lock_q}, wdata_q, wstrb_q);
  wire [31:0] sdram_new = bics_merge({16'h0000, sdram_q}, wdata_q, wstrb_q);
  wire [31:0] limit_new = bics_merge({16'h0000, limit_q}, wdata_q, wstrb_q);

  wire sys_open   = supervisor_mode | unlock_q | ~sys_written_q;   // RULE2 RULE4 RULE5
  wire sdram_open = supervisor_mode | unlock_q | ~sdram_written_q; // RULE3 RULE4 RULE5

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sys_cfg_q       <= `BICS_SYS_CFG_RST; // RULE1
      lock_q          <= `BICS_HALF_ZERO;   // RULE7
      sdram_q         <= `BICS_HALF_ZERO;   // RULE6
      limit_q         <= `BICS_TEN_DISABLED;
      sys_written_q   <= 1'b0;              // RULE20
      sdram_written_q <= 1'b0;              // RULE20
    end
    else
    begin
      if (wr_sys)
      begin
        sys_written_q <= 1'b1; // RULE2
        if (sys_open)
          sys_cfg_q <= sys_new[`BICS_SYS_CFG_W-1:0];
      end
      if (wr_sdram)
      begin
        sdram_written_q <= 1'b1; // RULE3
        if (sdram_open)
          sdram_q <= sdram_new[`BICS_HALF_W-1:0];
      end
      if (wr_lock)
        lock_q <= lock_new[`BICS_HALF_W-1:0];
      if (wr_limit)
        limit_q <= limit_new[`BICS_HALF_W-1:0]; // RULE15
    end
  end

  // ****************************************************************
  // Error flags
  // ****************************************************************
  reg [3:0] err_q;
  wire      rd_take;
  wire      rd_clear;

  wire [3:0] err_set = {self_read_evt,                                     // RULE11
                        sdram_access_evt & ~sdram_q[`BICS_SDRAM_EN_BIT],   // RULE12
                        auto_dma_uninit_evt,                               // RULE13
                        bcast_read_evt};                                   // RULE14

  // A new event in the clearing cycle survives: set wins over clear
  always @(posedge aclk)
  begin
    if (!aresetn)
      err_q <= 4'h0;
    else if (rd_take && rd_clear)
      err_q <= err_set; // RULE10
    else
      err_q <= err_q | err_set;
  end

  wire [31:0] status_word = {12'h000, err_q, strap_hi_q, 4'h0, strap_lo_q}; // RULE8

  // ****************************************************************
  // Bus tenure counter
  // ****************************************************************
  reg [`BICS_HALF_W-1:0] count_q;
  reg                    master_q;
  reg                    release_q;

  wire ten_enabled = (limit_q != `BICS_TEN_DISABLED); // RULE17
  wire ten_grant   = bus_master & ~master_q;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q   <= `BICS_TEN_DISABLED; // RULE18
      master_q  <= 1'b0;
      release_q <= 1'b0;
    end
    else
    begin
      master_q <= bus_master;
      if (!bus_master)
      begin
        count_q   <= `BICS_TEN_DISABLED;
        release_q <= 1'b0;
      end
      else if (ten_grant)
      begin
        count_q   <= ten_enabled ? limit_q : `BICS_TEN_DISABLED; // RULE17 RULE19
        release_q <= 1'b0;
      end
      else if (count_q != `BICS_TEN_DISABLED)
      begin
        if (count_q == `BICS_TEN_EXPIRED)
          release_q <= 1'b1; // RULE19
        else
          count_q <= count_q - 16'h0001; // RULE19
      end
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  reg        arready_q;
  reg        rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0]  rresp_q;
  reg [31:0] rd_word;
  reg        rd_hit;

  wire [`BICS_IDX_W-1:0] ridx = s_axi_araddr[`BICS_IDX_W+1:2];

  assign rd_take  = s_axi_arvalid & arready_q;
  assign rd_clear = (ridx == `BICS_IDX_SYS_STAT_CL);

  always @*
  begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case (ridx)
      `BICS_IDX_SYS_CFG:     rd_word = {10'h000, sys_cfg_q};
      `BICS_IDX_BUS_LOCK:    rd_word = {16'h0000, lock_q};   // RULE7
      `BICS_IDX_SDRAM_CFG:   rd_word = {16'h0000, sdram_q};  // RULE6
      `BICS_IDX_SYS_STAT:    rd_word = status_word;          // RULE9
      `BICS_IDX_SYS_STAT_CL: rd_word = status_word;          // RULE10
      `BICS_IDX_TEN_LIMIT:   rd_word = {16'h0000, limit_q};  // RULE16
      `BICS_IDX_TEN_COUNT:   rd_word = {16'h0000, count_q};  // RULE18
      default:               rd_hit  = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `BICS_RESP_OKAY;
    end
    else if (rd_take)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_hit ? `BICS_RESP_OKAY : `BICS_RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready    = awready_q;
  assign s_axi_wready     = wready_q;
  assign s_axi_bvalid     = bvalid_q;
  assign s_axi_bresp      = bresp_q;
  assign s_axi_arready    = arready_q;
  assign s_axi_rvalid     = rvalid_q;
  assign s_axi_rdata      = rdata_q;
  assign s_axi_rresp      = rresp_q;
  assign bus_release_req  = release_q;
  assign system_config    = sys_cfg_q;
  assign bus_lock_control = lock_q;
  assign sdram_config     = sdram_q;

endmodule // bics_regs

`default_nettype wire

// [dv/bics_bus_peer.sv]
// Model of the other masters sharing the external bus
`timescale 1ns/10ps
`default_nettype none

module bics_bus_peer (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic want,
  input  wire logic bcast_go,
  input  wire logic bus_release_req,
  output var  logic bus_master,
  output var  logic bcast_read_evt
);
  // ****************
  // Arbitration
  // ****************
  // A waiting master takes the bus at once when release is asked
  always @(posedge aclk)
    if (!aresetn)
    begin
      bus_master     <= 1'b0;
      bcast_read_evt <= 1'b0;
    end
    else
    begin
      bus_master     <= want && !bus_release_req;
      bcast_read_evt <= bcast_go;
    end
endmodule // bics_bus_peer

`default_nettype wire

// [dv/bics_regs_chk.sv]
// Port checks of the bus interface config/status bank
`timescale 1ns/10ps
`default_nettype none
`include "bics_defs.vh"

module bics_regs_chk #(
  parameter ADDR_W = 23
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              bus_master,
  input wire logic              bus_release_req,
  input wire logic [21:0]       system_config,
  input wire logic [15:0]       bus_lock_control,
  input wire logic [15:0]       sdram_config
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [20:0] ix_q;
  logic [15:0] wd_q;
  logic [15:0] lim_q;

  // ****************
  // Limit shadow
  // ****************
  // Lags the register by a cycle; grants never follow a write that closely
  always @(posedge aclk)
    if (!aresetn)
    begin
      ix_q  <= 21'h000000;
      wd_q  <= 16'h0000;
      lim_q <= `BICS_TEN_DISABLED;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        ix_q <= s_axi_awaddr[ADDR_W-1:2];
      if (s_axi_wvalid && s_axi_wready)
        wd_q <= s_axi_wdata[15:0];
      if (s_axi_bvalid && s_axi_bready && ix_q == `BICS_IDX_TEN_LIMIT)
        lim_q <= wd_q;
    end

  // ****************
  // Properties
  // ****************
  property p_rst;
    $rose(aresetn) |-> system_config == `BICS_SYS_CFG_RST && sdram_config == 16'h0000
      && bus_lock_control == 16'h0000 && !s_axi_bvalid;
  endproperty
  a_rst: assert property (p_rst)
    else $error("Config outputs not at reset values");

  property p_cfg_src;
    $changed({system_config, sdram_config, bus_lock_control})
      |-> s_axi_bvalid && s_axi_bresp == `BICS_RESP_OKAY;
  endproperty
  a_cfg_src: assert property (p_cfg_src)
    else $error("Config changed without an accepted write");

  property p_ro_err;
    s_axi_bvalid && (ix_q == `BICS_IDX_SYS_STAT || ix_q == `BICS_IDX_SYS_STAT_CL
      || ix_q == `BICS_IDX_TEN_COUNT) |-> s_axi_bresp == `BICS_RESP_SLVERR;
  endproperty
  a_ro_err: assert property (p_ro_err)
    else $error("Write to read-only word not refused");

  property p_rel_drop;
    !bus_master |=> !bus_release_req;
  endproperty
  a_rel_drop: assert property (p_rel_drop)
    else $error("Release request without mastership");

  property p_rel_hold;
    bus_release_req && bus_master |=> bus_release_req;
  endproperty
  a_rel_hold: assert property (p_rel_hold)
    else $error("Release request dropped while master");

  property p_rel_rise;
    $rose(bus_release_req) |-> $past(bus_master) && $past(bus_master, 2);
  endproperty
  a_rel_rise: assert property (p_rel_rise)
    else $error("Release request rose too early");

  property p_rel_time;
    $rose(bus_master) && lim_q == 16'h0002 |=> !bus_release_req [*3] ##1 bus_release_req;
  endproperty
  a_rel_time: assert property (p_rel_time)
    else $error("Tenure expiry at wrong cycle");

  property p_off;
    $rose(bus_master) && lim_q == `BICS_TEN_DISABLED |=> !bus_release_req [*8];
  endproperty
  a_off: assert property (p_off)
    else $error("Disabled tenure counter expired");

  c_rel: cover property (bus_release_req);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == `BICS_RESP_SLVERR);
  c_ten: cover property ($rose(bus_master) && lim_q == 16'h0002);
endmodule // bics_regs_chk

bind bics_regs bics_regs_chk #(.ADDR_W(ADDR_W)) i_bics_regs_chk (.*);

`default_nettype wire

// [dv/bics_regs_tb.sv]
// Self-checking bench of the bus interface config/status bank
`timescale 1ns/10ps
`default_nettype none
`include "bics_defs.vh"

module bics_regs_tb;
  localparam [20:0] CFG  = `BICS_IDX_SYS_CFG;
  localparam [20:0] SDR  = `BICS_IDX_SDRAM_CFG;
  localparam [20:0] STA  = `BICS_IDX_SYS_STAT;
  localparam [20:0] LCK  = `BICS_IDX_BUS_LOCK;
  localparam [20:0] LIM  = `BICS_IDX_TEN_LIMIT;
  localparam [20:0] CNT  = `BICS_IDX_TEN_COUNT;
  localparam [1:0]  OK   = `BICS_RESP_OKAY;
  localparam [1:0]  SE   = `BICS_RESP_SLVERR;
  localparam [31:0] BASE = 32'h0000A509;

  logic        aclk;
  logic        aresetn;
  logic [22:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  logic        supervisor_mode, config_write_unlock_strap, want;
  logic [7:0]  status_strap_hi;
  logic [3:0]  status_strap_lo;
  logic [3:0]  ev;
  wire         self_read_evt       = ev[3];
  wire         sdram_access_evt    = ev[2];
  wire         auto_dma_uninit_evt = ev[1];
  wire         bcast_go            = ev[0];
  wire         bcast_read_evt, bus_master, bus_release_req;
  wire  [21:0] system_config;
  wire  [15:0] bus_lock_control, sdram_config;
  integer      bad_count = 0, checked = 0, cyc = 0, n, i;
  logic [20:0] rix [6]  = '{CFG, LCK, SDR, STA, LIM, CNT};
  logic [31:0] rexp [6] = '{32'h00009067, 32'h0, 32'h0, BASE, 32'h0000FFFF, 32'h0000FFFF};

  bics_regs #(.ADDR_W(23)) i_bics_regs (.*);
  bics_bus_peer i_bics_bus_peer (.*);

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Whole sequence needs well under a thousand cycles
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  end

  // ****************
  // Access tasks
  // ****************
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  task wr(input logic [20:0] ix, input logic [31:0] d, input logic [1:0] er);
    logic a, w, b;
    begin
      @(posedge aclk);
      s_axi_awaddr <= {ix, 2'b00};
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      {a, w, b} = 3'h7;
      while (b)
      begin
        @(posedge aclk);
        if (a && s_axi_awready)
        begin
          s_axi_awvalid <= 1'b0;
          a = 1'b0;
        end
        if (w && s_axi_wready)
        begin
          s_axi_wvalid <= 1'b0;
          w = 1'b0;
        end
        if (s_axi_bvalid === 1'b1)
        begin
          s_axi_bready <= 1'b0;
          b = 1'b0;
          chk({30'h0, s_axi_bresp}, {30'h0, er});
        end
      end
    end
  endtask

  task rd(input logic [20:0] ix, input logic [31:0] e, input logic [1:0] er);
    logic a, r;
    begin
      @(posedge aclk);
      s_axi_araddr <= {ix, 2'b00};
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      {a, r} = 2'h3;
      while (r)
      begin
        @(posedge aclk);
        if (a && s_axi_arready)
        begin
          s_axi_arvalid <= 1'b0;
          a = 1'b0;
        end
        if (s_axi_rvalid === 1'b1)
        begin
          s_axi_rready <= 1'b0;
          r = 1'b0;
          chk(s_axi_rdata, e);
          chk({30'h0, s_axi_rresp}, {30'h0, er});
        end
      end
    end
  endtask

  task pulse(input logic [3:0] v);
    begin
      @(posedge aclk);
      ev <= v;
      @(posedge aclk);
      ev <= 4'h0;
    end
  endtask

  task rst(input logic s);
    begin
      @(posedge aclk);
      aresetn <= 1'b0;
      config_write_unlock_strap <= s;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
    end
  endtask

  task tally_and_finish;
    begin
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // ****************
  // Scenarios
  // ****************
  initial
  begin
    {aresetn, config_write_unlock_strap, supervisor_mode, want, ev} = 8'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 78'h0;
    s_axi_wstrb = 4'hF;
    status_strap_hi = 8'hA5;
    status_strap_lo = 4'h9;
    rst(1'b0);
    for (i = 0; i < 6; i = i + 1)
      rd(rix[i], rexp[i], OK);
    rd(21'h1F0081, 32'h00000000, SE);
    for (i = 0; i < 4; i = i + 1)
    begin
      pulse(4'h8 >> i);
      rd(STA, BASE | (32'h00080000 >> i), OK);
      rd(`BICS_IDX_SYS_STAT_CL, BASE | (32'h00080000 >> i), OK);
      rd(STA, BASE, OK);
    end
    wr(STA, 32'hFFFFFFFF, SE);
    wr(CNT, 32'h00000000, SE);
    rd(STA, BASE, OK);
    wr(CFG, 32'hFFFF1234, OK);
    wr(CFG, 32'h00000001, OK);
    rd(CFG, 32'h003F1234, OK);
    chk({10'h000, system_config}, 32'h003F1234);
    wr(SDR, 32'hFFFF00F0, OK);
    wr(SDR, 32'h00000001, OK);
    rd(SDR, 32'h000000F0, OK);
    chk({16'h0000, sdram_config}, 32'h000000F0);
    supervisor_mode <= 1'b1;
    wr(CFG, 32'h00000055, OK);
    rd(CFG, 32'h00000055, OK);
    wr(SDR, 32'h00000001, OK);
    rd(SDR, 32'h00000001, OK);
    pulse(4'h4);
    rd(STA, BASE, OK);
    wr(LCK, 32'hFFFF00C3, OK);
    rd(LCK, 32'h000000C3, OK);
    // Only byte lane 1 enabled: the low byte must survive the merge
    s_axi_wstrb <= 4'h2;
    wr(LCK, 32'h0000AA55, OK);
    s_axi_wstrb <= 4'hF;
    rd(LCK, 32'h0000AAC3, OK);
    chk({16'h0000, bus_lock_control}, 32'h0000AAC3);
    supervisor_mode <= 1'b0;
    wr(LIM, 32'hABCD0002, OK);
    want <= 1'b1;
    n = 0;
    while (bus_master !== 1'b1)
      @(posedge aclk);
    while (bus_release_req !== 1'b1)
    begin
      @(posedge aclk);
      n = n + 1;
    end
    want <= 1'b0;
    chk(n, 32'h00000004);
    repeat (3) @(posedge aclk);
    rd(LIM, 32'h00000002, OK);
    rd(CNT, 32'h0000FFFF, OK);
    wr(LIM, 32'h0000FFFF, OK);
    want <= 1'b1;
    while (bus_master !== 1'b1)
      @(posedge aclk);
    repeat (20)
    begin
      @(posedge aclk);
      chk({31'h0, bus_release_req}, 32'h0);
    end
    rd(CNT, 32'h0000FFFF, OK);
    want <= 1'b0;
    rst(1'b1);
    wr(CFG, 32'h00000011, OK);
    wr(CFG, 32'h00000022, OK);
    rd(CFG, 32'h00000022, OK);
    wr(SDR, 32'h00000002, OK);
    wr(SDR, 32'h00000004, OK);
    rd(SDR, 32'h00000004, OK);
    rst(1'b0);
    wr(CFG, 32'h00000033, OK);
    rd(CFG, 32'h00000033, OK);
    tally_and_finish;
  end
endmodule // bics_regs_tb

`default_nettype wire
